// ---- hw/irq_pkg.sv ----
// Constants, register layout and field positions of the periodic tick and interrupt request block.
// Assumes a 32-bit APB slave on pclk with byte addresses; the interrupt logic, the tick divider and the bench import this package.
//
// Function
// - Each tick overflow sets its own flag.
// - Tick vectors need global enable, own enable, free stack.
// - Taking tick clears its flag and global enable.
// - Three-bit field picks tick0 division ratio.
// - Top control bit gates both tick counters; resets 0.
// - Clock select: dedicated tick clock or divided system.
// - Memory write completion sets write-done flag.
// - Write-done vectors need global, own enable, free stack.
// - Servicing write-done clears global enable and flag.
// - Each timer module: compare P and A flags, enables.
// - Timer vectors need global, individual, group enables, stack.
// - Timer service clears group flag, global enable only.
// - Any flag rising during sleep wakes processor.
// - Set flags stay set until serviced or cleared.
// - Only program counter is pushed on vectoring.
// - Handler return restores global enable; plain return not.
// - Group flag set when a grouped flag sets.
// - Full stack blocks every acknowledge until popped.
package irq_pkg;

    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;

    // Register byte offsets.
    localparam logic [7:0]  TICK_CTRL_OFS   = 8'h00;
    localparam logic [7:0]  IRQ_CTRL_OFS    = 8'h04;
    localparam logic [7:0]  TM0_OFS         = 8'h08;
    localparam logic [7:0]  TM1_OFS         = 8'h0C;

    // Tick control register: fields, implemented bits and reset value.
    localparam int          TICK_ON_POS     = 7;
    localparam int          TICK_SEL_POS    = 6;
    localparam int          TICK1_PER_POS   = 4;
    localparam int          TICK0_PER_POS   = 0;
    localparam logic [7:0]  TICK_CTRL_MASK  = 8'hF7;
    localparam logic [7:0]  TICK_CTRL_RST   = 8'h37;

    // Interrupt control register: enables, global enable, flags.
    localparam int          NUM_SRC         = 5;
    localparam int          IEN_POS         = 0;
    localparam int          GIE_POS         = 7;
    localparam int          FLAG_POS        = 8;

    // Source indices, in priority order (0 is served first).
    localparam int          SRC_TICK0       = 0;
    localparam int          SRC_TICK1       = 1;
    localparam int          SRC_NVM         = 2;
    localparam int          SRC_GRP0        = 3;
    localparam int          NUM_TM          = 2;

    // Timer module register fields.
    localparam int          TM_PE_POS       = 0;
    localparam int          TM_AE_POS       = 1;
    localparam int          TM_PF_POS       = 4;
    localparam int          TM_AF_POS       = 5;

    // Tick divider: system clock prescale and period base exponents.
    localparam logic [1:0]  SYS_TICK_DIV_M1 = 2'h3;
    localparam int          CNT_W           = 16;
    localparam int          TICK0_BASE_LOG2 = 8;
    localparam int          TICK1_BASE_LOG2 = 12;

endpackage

// ---- hw/periodic_eeprom_timer_irq_logic.sv ----
// Interrupt request logic: tick, memory write-done and timer compare sources, vectoring and wake.
// Assumes an APB master on pclk, a core that acts on the take pulse, and synchronous event inputs.
`timescale 1ns/1ps
`default_nettype none
module periodic_eeprom_timer_irq_logic (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [irq_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [irq_pkg::DATA_W-1:0]    pwdata,
    output logic      [irq_pkg::DATA_W-1:0]    prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          dedicated_tick_clock,
    input  wire logic                          nvm_write_done,
    input  wire logic [irq_pkg::NUM_TM-1:0]    timer_cmp_p_match,
    input  wire logic [irq_pkg::NUM_TM-1:0]    timer_cmp_a_match,
    input  wire logic                          stack_full,
    input  wire logic                          return_from_handler,
    input  wire logic                          plain_subroutine_return,
    input  wire logic                          sleep_active,
    output logic                               irq_take,
    output logic      [2:0]                    irq_vector,
    output logic                               push_pc_only,
    output logic                               wake_request,
    output logic                               global_irq_enable
);
    import irq_pkg::*;

    typedef struct packed {
        logic [7:0]          tick_ctrl;
        logic                gie;
        logic [NUM_SRC-1:0]  en;
        logic [NUM_SRC-1:0]  flag;
        logic [NUM_TM-1:0]   tm_pe;
        logic [NUM_TM-1:0]   tm_ae;
        logic [NUM_TM-1:0]   tm_pf;
        logic [NUM_TM-1:0]   tm_af;
        logic                take;
        logic [2:0]          vec;
        logic                wake;
        logic [DATA_W-1:0]   prdata;
        logic                pready;
        logic                pslverr;
    } irq_state_type;

    localparam irq_state_type STATE_RST = '{
        tick_ctrl: TICK_CTRL_RST,
        default:   '0
    };

    irq_state_type       r;
    irq_state_type       n;
    logic [NUM_SRC-1:0]  pend;
    logic [NUM_TM-1:0]   tm_active;
    logic [NUM_TM-1:0]   tm_rise;
    logic [NUM_SRC-1:0]  flag_before;
    logic                wr_done;
    logic                setup;
    logic                sel_found;
    logic [2:0]          sel_idx;

    tick_if tif ();

    // Word decode of an APB address against a register offset.
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
    endfunction

    // Offset of timer module m's register.
    function automatic logic [7:0] tm_ofs(input int m);
        return (m == 0) ? TM0_OFS : TM1_OFS;
    endfunction

    // True when the address falls on any implemented register.
    function automatic logic any_hit(input logic [ADDR_W-1:0] a);
        return reg_hit(a, TICK_CTRL_OFS) | reg_hit(a, IRQ_CTRL_OFS)
             | reg_hit(a, TM0_OFS) | reg_hit(a, TM1_OFS);
    endfunction

    // Tick control fields drive the divider.
    assign tif.units_on       = r.tick_ctrl[TICK_ON_POS];
    assign tif.clock_select   = r.tick_ctrl[TICK_SEL_POS];
    assign tif.tick0_period   = r.tick_ctrl[TICK0_PER_POS +: 3];
    assign tif.tick1_period   = r.tick_ctrl[TICK1_PER_POS +: 2];
    assign tif.dedicated_tick = dedicated_tick_clock;

    tick_divider u_tick_divider (
        .pclk    (pclk),
        .presetn (presetn),
        .tif     (tif)
    );

    // A timer module asks for its group when an enabled compare flag is set.
    genvar gm;
    generate
        for (gm = 0; gm < NUM_TM; gm++) begin : g_tm
            assign tm_active[gm] = (r.tm_pf[gm] & r.tm_pe[gm])
                                 | (r.tm_af[gm] & r.tm_ae[gm]);
        end
    endgenerate

    // Pending sources: flag and own enable, plus module enable for groups.
    always_comb begin
        pend = r.flag & r.en;
        for (int m = 0; m < NUM_TM; m++) begin
            pend[SRC_GRP0 + m] = r.flag[SRC_GRP0 + m] & r.en[SRC_GRP0 + m]
                               & tm_active[m];
        end
    end

    // Fixed priority pick: the lowest pending index wins, others stay pending.
    always_comb begin
        sel_found = 1'b0;
        sel_idx   = 3'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                sel_found = 1'b1;
                sel_idx   = 3'(i);
            end
        end
    end

    assign setup   = psel & ~penable;
    assign wr_done = psel & penable & r.pready & pwrite;

    // Next state of registers, flags, vectoring and the bus answer.
    always_comb begin
        n = r;
        n.take = 1'b0;
        n.wake = 1'b0;
        tm_rise = '0;
        flag_before = '0;

        // Bus answer: ready in the first access cycle, error on unmapped words.
        n.pready  = setup;
        n.pslverr = setup & ~any_hit(paddr);
        n.prdata  = '0;
        if (setup) begin
            if (reg_hit(paddr, TICK_CTRL_OFS)) begin
                n.prdata[7:0] = r.tick_ctrl;
            end
            if (reg_hit(paddr, IRQ_CTRL_OFS)) begin
                n.prdata[IEN_POS +: NUM_SRC]  = r.en;
                n.prdata[GIE_POS]             = r.gie;
                n.prdata[FLAG_POS +: NUM_SRC] = r.flag;
            end
            for (int m = 0; m < NUM_TM; m++) begin
                if (reg_hit(paddr, tm_ofs(m))) begin
                    n.prdata[TM_PE_POS] = r.tm_pe[m];
                    n.prdata[TM_AE_POS] = r.tm_ae[m];
                    n.prdata[TM_PF_POS] = r.tm_pf[m];
                    n.prdata[TM_AF_POS] = r.tm_af[m];
                end
            end
        end

        // Software writes; flags may be set or cleared by software.
        if (wr_done && reg_hit(paddr, TICK_CTRL_OFS)) begin
            n.tick_ctrl = pwdata[7:0] & TICK_CTRL_MASK;
        end
        if (wr_done && reg_hit(paddr, IRQ_CTRL_OFS)) begin
            n.en   = pwdata[IEN_POS +: NUM_SRC];
            n.gie  = pwdata[GIE_POS];
            n.flag = pwdata[FLAG_POS +: NUM_SRC];
        end
        for (int m = 0; m < NUM_TM; m++) begin
            if (wr_done && reg_hit(paddr, tm_ofs(m))) begin
                n.tm_pe[m] = pwdata[TM_PE_POS];
                n.tm_ae[m] = pwdata[TM_AE_POS];
                n.tm_pf[m] = pwdata[TM_PF_POS];
                n.tm_af[m] = pwdata[TM_AF_POS];
            end
        end

        // Handler return sets the global enable; a plain return leaves it.
        if (return_from_handler) begin
            n.gie = 1'b1;
        end

        // Vectoring: needs global enable and a stack with room.
        if (r.gie && !stack_full && sel_found && !r.take) begin
            n.take = 1'b1;
            n.vec  = sel_idx;
            n.gie  = 1'b0;
            n.flag[sel_idx] = 1'b0;
        end

        // Hardware events set flags last so that they win over any clear.
        n.tm_pf = n.tm_pf | timer_cmp_p_match;
        n.tm_af = n.tm_af | timer_cmp_a_match;
        n.flag[SRC_TICK0] = n.flag[SRC_TICK0] | tif.tick0_overflow;
        n.flag[SRC_TICK1] = n.flag[SRC_TICK1] | tif.tick1_overflow;
        n.flag[SRC_NVM]   = n.flag[SRC_NVM] | nvm_write_done;

        // A newly set module flag raises its group flag.
        for (int m = 0; m < NUM_TM; m++) begin
            tm_rise[m] = (n.tm_pf[m] & ~r.tm_pf[m]) | (n.tm_af[m] & ~r.tm_af[m]);
            n.flag[SRC_GRP0 + m] = n.flag[SRC_GRP0 + m] | tm_rise[m];
        end

        // Any flag rising while asleep wakes the core, enables ignored.
        flag_before = r.flag;
        n.wake = sleep_active & ((|(n.flag & ~flag_before)) | (|tm_rise));
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= STATE_RST;
        end else begin
            r <= n;
        end
    end

    // Outputs come straight from the state register.
    assign prdata            = r.prdata;
    assign pready            = r.pready;
    assign pslverr           = r.pslverr;
    assign irq_take          = r.take;
    assign irq_vector        = r.vec;
    assign push_pc_only      = r.take;
    assign wake_request      = r.wake;
    assign global_irq_enable = r.gie;

    // Unused by the block itself: the core handles the pop of a plain return.
    logic unused_ok;
    assign unused_ok = plain_subroutine_return;

endmodule
`default_nettype wire

// ---- hw/tick_divider.sv ----
// Programmable tick divider producing the two periodic overflow pulses.
// Assumes one pclk domain; the dedicated tick clock arrives as a one-cycle enable.
`timescale 1ns/1ps
`default_nettype none
module tick_divider (
    input  wire logic pclk,
    input  wire logic presetn,
    tick_if.div       tif
);
    import irq_pkg::*;

    typedef struct packed {
        logic [1:0]       pre;
        logic [CNT_W-1:0] cnt;
        logic             ovf0;
        logic             ovf1;
    } div_state_type;

    div_state_type r;
    div_state_type n;
    logic          src_tick;

    // Mask of the low counter bits that span one period of 2^bits source ticks.
    function automatic logic [CNT_W-1:0] period_mask(input int bits);
        logic [CNT_W:0] one_hot;
        one_hot = (CNT_W+1)'(1) << bits;
        return CNT_W'(one_hot - (CNT_W+1)'(1));
    endfunction

    // Next state: prescaler, shared counter and overflow pulses.
    always_comb begin
        n = r;
        n.ovf0 = 1'b0;
        n.ovf1 = 1'b0;
        n.pre = r.pre + 2'h1;
        src_tick = tif.clock_select ? (r.pre == SYS_TICK_DIV_M1)
                                    : tif.dedicated_tick;
        if (!tif.units_on) begin
            n.cnt = '0;
        end else if (src_tick) begin
            n.cnt = r.cnt + CNT_W'(1);
            // Overflow when all low bits of the selected period are ones.
            n.ovf0 = (r.cnt & period_mask(TICK0_BASE_LOG2 + int'(tif.tick0_period)))
                     == period_mask(TICK0_BASE_LOG2 + int'(tif.tick0_period));
            n.ovf1 = (r.cnt & period_mask(TICK1_BASE_LOG2 + int'(tif.tick1_period)))
                     == period_mask(TICK1_BASE_LOG2 + int'(tif.tick1_period));
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // Overflow pulses come straight from flip-flops.
    assign tif.tick0_overflow = r.ovf0;
    assign tif.tick1_overflow = r.ovf1;

endmodule
`default_nettype wire

// ---- hw/tick_if.sv ----
// Interface carrying tick configuration to the divider and its overflow pulses back.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
    logic        units_on;
    logic        clock_select;
    logic [2:0]  tick0_period;
    logic [1:0]  tick1_period;
    logic        dedicated_tick;
    logic        tick0_overflow;
    logic        tick1_overflow;

    modport ctrl (output units_on, clock_select, tick0_period, tick1_period, dedicated_tick,
                  input tick0_overflow, tick1_overflow);
    modport div  (input units_on, clock_select, tick0_period, tick1_period, dedicated_tick,
                  output tick0_overflow, tick1_overflow);
endinterface
`default_nettype wire

// ---- test/core_model.sv ----
// Model of the core's program sequencer and return stack facing the interrupt block.
// Assumes pclk and presetn of the block; the bench steers fill and use_plain.
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic irq_take,
    input  wire logic fill,
    input  wire logic use_plain,
    output logic      stack_full,
    output logic      return_from_handler,
    output logic      plain_subroutine_return
);
    logic [3:0] depth_r;
    logic [5:0] wait_r;
    logic       slow_r;
    // Nested calls in a handler are what fill the stack, so the bench forces it.
    assign stack_full = fill || (depth_r == 4'h8);
    // Pushes only the return address, runs a short or long handler, then returns.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            depth_r <= 4'h0;
            wait_r <= 6'h00;
            slow_r <= 1'b0;
            return_from_handler <= 1'b0;
            plain_subroutine_return <= 1'b0;
        end else begin
            return_from_handler <= 1'b0;
            plain_subroutine_return <= 1'b0;
            if (irq_take) begin
                depth_r <= depth_r + 4'h1;
                wait_r <= slow_r ? 6'h28 : 6'h0C;
                slow_r <= !slow_r;
            end else if (wait_r != 6'h00) begin
                wait_r <= wait_r - 6'h01;
                if (wait_r == 6'h01) begin
                    depth_r <= depth_r - 4'h1;
                    return_from_handler <= !use_plain;
                    plain_subroutine_return <= use_plain;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- test/irq_checker.sv ----
// Assertions on the top ports of the interrupt request block.
// Assumes one pclk domain with an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module irq_checker (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       pwrite,
    input wire logic       stack_full,
    input wire logic       return_from_handler,
    input wire logic       plain_subroutine_return,
    input wire logic       sleep_active,
    input wire logic       irq_take,
    input wire logic [2:0] irq_vector,
    input wire logic       push_pc_only,
    input wire logic       wake_request,
    input wire logic       global_irq_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A call needs the global enable and a free stack at the deciding edge.
    property p_take_cause;
        irq_take |-> $past(global_irq_enable) && !$past(stack_full);
    endproperty
    property p_take_clear;
        irq_take |-> !global_irq_enable;
    endproperty
    property p_take_pulse;
        irq_take |=> !irq_take;
    endproperty
    property p_pc_only;
        push_pc_only == irq_take;
    endproperty
    property p_full_block;
        stack_full |=> !irq_take;
    endproperty
    property p_return_from_handler;
        return_from_handler && !global_irq_enable |=> global_irq_enable;
    endproperty
    property p_plain_ret;
        plain_subroutine_return && !global_irq_enable && !return_from_handler
            && !(psel && pwrite) |=> !global_irq_enable;
    endproperty
    property p_vec_hold;
        !irq_take |-> $stable(irq_vector);
    endproperty
    property p_wake_sleep;
        wake_request |-> $past(sleep_active);
    endproperty
    a_take_cause: assert property (p_take_cause) else $error("call without cause");
    a_take_clear: assert property (p_take_clear) else $error("enable kept");
    a_take_pulse: assert property (p_take_pulse) else $error("long call");
    a_pc_only: assert property (p_pc_only) else $error("push mismatch");
    a_full_block: assert property (p_full_block) else $error("call on full");
    a_return_from_handler: assert property (p_return_from_handler) else $error("enable not set");
    a_plain_ret: assert property (p_plain_ret) else $error("enable set");
    a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
    a_wake_sleep: assert property (p_wake_sleep) else $error("wake awake");
    c_take: cover property (irq_take);
    c_wake: cover property (wake_request);
    c_full: cover property (stack_full ##1 !irq_take);
    c_return_from_handler: cover property (return_from_handler);
endmodule
bind periodic_eeprom_timer_irq_logic irq_checker chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .pwrite(pwrite), .stack_full(stack_full),
    .return_from_handler(return_from_handler), .sleep_active(sleep_active),
    .plain_subroutine_return(plain_subroutine_return), .irq_take(irq_take),
    .irq_vector(irq_vector), .push_pc_only(push_pc_only), .wake_request(wake_request),
    .global_irq_enable(global_irq_enable)
);
`default_nettype wire

// ---- test/periodic_eeprom_timer_irq_logic_test.sv ----
// Self-checking bench of the interrupt request block beside a core model.
// Assumes the package, core model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module periodic_eeprom_timer_irq_logic_test;
    import irq_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h8B4CE121;
    logic        pready, pslverr, dedicated_tick_clock = 1'b0, nvm_write_done = 1'b0;
    logic [1:0]  timer_cmp_p_match = 2'h0, timer_cmp_a_match = 2'h0;
    logic        stack_full, return_from_handler, plain_subroutine_return, sleep_active = 1'b0;
    logic        irq_take, push_pc_only, wake_request, global_irq_enable;
    logic        fill = 1'b0, use_plain = 1'b0;
    logic [2:0]  irq_vector;
    logic [31:0] rq[$];
    logic [2:0]  vq[$];
    logic        eq[$];
    int          n_errors = 0, total_checks = 0, wakes = 0, cyc = 0, w0;

    periodic_eeprom_timer_irq_logic dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dedicated_tick_clock(dedicated_tick_clock), .nvm_write_done(nvm_write_done),
        .timer_cmp_p_match(timer_cmp_p_match), .timer_cmp_a_match(timer_cmp_a_match),
        .stack_full(stack_full), .return_from_handler(return_from_handler),
        .plain_subroutine_return(plain_subroutine_return), .sleep_active(sleep_active),
        .irq_take(irq_take), .irq_vector(irq_vector), .push_pc_only(push_pc_only),
        .wake_request(wake_request), .global_irq_enable(global_irq_enable));
    core_model core (
        .pclk(pclk), .presetn(presetn), .irq_take(irq_take), .fill(fill), .use_plain(use_plain),
        .stack_full(stack_full), .return_from_handler(return_from_handler),
        .plain_subroutine_return(plain_subroutine_return));

    // Free-running clock.
    always #2.5 pclk = ~pclk;

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Random dedicated tick pulses, cycle count and wake count.
    always @(posedge pclk) begin
        seed <= xorshift(seed);
        dedicated_tick_clock <= seed[0];
        cyc <= cyc + 1;
        if (wake_request) wakes <= wakes + 1;
    end

    task automatic chk_data(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_vec(input string what, input logic [2:0] e, input logic [2:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    // Takes the oldest note whenever a read completes or a vector call appears.
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            chk_data("read data", rq.pop_front(), prdata);
            chk_data("slave error", {31'h0, eq.pop_front()}, {31'h0, pslverr});
        end
        if (irq_take && vq.size() == 0) chk_vec("unexpected vector", 3'h7, irq_vector);
        else if (irq_take) chk_vec("vector", vq.pop_front(), irq_vector);
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // The request holds until the answer comes; only the watchdog ends a hang.
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        // Words above the last timer register are unmapped and answer with an error.
        eq.push_back(a > TM1_OFS);
        apb(1'b0, a, 32'h0);
    endtask

    // Pulses {cmp A, cmp P, write done} for one cycle.
    task automatic ev(input logic [4:0] e);
        @(posedge pclk);
        {timer_cmp_a_match, timer_cmp_p_match, nvm_write_done} <= e;
        @(posedge pclk);
        {timer_cmp_a_match, timer_cmp_p_match, nvm_write_done} <= 5'h00;
    endtask

    task automatic drain(input int n);
        repeat (n) if (vq.size() != 0) @(posedge pclk);
        chk_data("pending vectors", 32'h0, vq.size());
    endtask

    task automatic tick_run(input logic [31:0] ctl, input logic [31:0] ien,
                            input logic [2:0] v, input int lo, input int hi);
        int t0;
        wr(IRQ_CTRL_OFS, ien);
        wr(TICK_CTRL_OFS, ctl);
        t0 = cyc;
        vq.push_back(v);
        drain(hi + 10);
        chk_data("tick period", 32'h1, {31'h0, (cyc - t0 >= lo) && (cyc - t0 <= hi)});
        wr(TICK_CTRL_OFS, 32'h0);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (40000) @(posedge pclk);
        n_errors++;
        $display("Error watchdog expected end seen hang");
        results();
    end

    // Main sequence.
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(TICK_CTRL_OFS, 32'h37);
        rd(IRQ_CTRL_OFS, 32'h0);
        rd(8'h10, 32'h0);
        w0 = seed & 32'h7F;
        wr(TICK_CTRL_OFS, w0);
        rd(TICK_CTRL_OFS, w0 & 32'hF7);
        $display("registers done");
        wr(IRQ_CTRL_OFS, 32'h04);
        ev(5'h01);
        rd(IRQ_CTRL_OFS, 32'h404);
        fill <= 1'b1;
        vq.push_back(3'(SRC_NVM));
        wr(IRQ_CTRL_OFS, 32'h484);
        repeat (20) @(posedge pclk);
        chk_data("calls while full", 32'h1, vq.size());
        fill <= 1'b0;
        drain(20);
        rd(IRQ_CTRL_OFS, 32'h004);
        repeat (50) @(posedge pclk);
        rd(IRQ_CTRL_OFS, 32'h084);
        use_plain <= 1'b1;
        vq.push_back(3'(SRC_NVM));
        ev(5'h01);
        drain(20);
        repeat (60) @(posedge pclk);
        rd(IRQ_CTRL_OFS, 32'h004);
        use_plain <= 1'b0;
        $display("write done source done");
        wr(IRQ_CTRL_OFS, 32'h707);
        vq = '{3'h0, 3'h1, 3'h2};
        wr(IRQ_CTRL_OFS, 32'h787);
        drain(200);
        repeat (50) @(posedge pclk);
        rd(IRQ_CTRL_OFS, 32'h087);
        $display("priority done");
        wr(TM0_OFS, 32'h01);
        wr(TM1_OFS, 32'h02);
        wr(IRQ_CTRL_OFS, 32'h098);
        ev(5'h08);
        repeat (10) @(posedge pclk);
        vq.push_back(3'h3);
        ev(5'h02);
        drain(20);
        repeat (50) @(posedge pclk);
        vq.push_back(3'h4);
        ev(5'h10);
        drain(20);
        rd(TM0_OFS, 32'h31);
        rd(TM1_OFS, 32'h22);
        repeat (50) @(posedge pclk);
        rd(IRQ_CTRL_OFS, 32'h098);
        $display("timer groups done");
        wr(IRQ_CTRL_OFS, 32'h0);
        sleep_active <= 1'b1;
        w0 = wakes;
        ev(5'h01);
        repeat (4) @(posedge pclk);
        chk_data("wakes", 32'h1, wakes - w0);
        ev(5'h01);
        repeat (4) @(posedge pclk);
        chk_data("wakes", 32'h1, wakes - w0);
        sleep_active <= 1'b0;
        $display("wake done");
        tick_run(32'hC0, 32'h81, 3'h0, 1014, 1054);
        repeat (1100) @(posedge pclk);
        tick_run(32'hC1, 32'h81, 3'h0, 2038, 2078);
        tick_run(32'h80, 32'h81, 3'h0, 300, 900);
        tick_run(32'hC0, 32'h82, 3'h1, 16374, 16414);
        $display("ticks done");
        results();
    end
endmodule
`default_nettype wire
